// ---- rtl/adcrb_defs.svh ----
// Register offsets, reset values and timing counts for the converter register bank
`ifndef ADCRB_DEFS_SVH
`define ADCRB_DEFS_SVH
`define ADCRB_OFF_EXT_CMD 8'h43
`define ADCRB_OFF_RES_LO 8'h50
`define ADCRB_OFF_RES_HI 8'h51
`define ADCRB_OFF_CTRL 8'h52
`define ADCRB_OFF_BIAS 8'h53
`define ADCRB_OFF_RATE 8'h54
`define ADCRB_OFF_GAIN 8'h55
`define ADCRB_OFF_OFF3 8'h56
`define ADCRB_OFF_INSEL 8'h57
`define ADCRB_OFF_MODE 8'h70
`define ADCRB_RST_EXT_CMD 8'h00
`define ADCRB_RST_CTRL 8'h28
`define ADCRB_RST_BIAS 8'hF0
`define ADCRB_RST_RATE 8'h00
`define ADCRB_RST_GAIN 8'h0C
`define ADCRB_RST_OFF3 8'h00
`define ADCRB_RST_INSEL 8'h00
`define ADCRB_RST_MODE 8'h84
`define ADCRB_EXT_ADDR_CMD 8'h96
`define ADCRB_ADDR_HIGH 3'h4
`define ADCRB_MODE_RSV_MASK 8'hC0
`define ADCRB_OSR_BASE 11'h008
`define ADCRB_CLK_KHZ 50000
`define ADCRB_FS_MAX_KHZ 500
`define ADCRB_FS_DIV (`ADCRB_CLK_KHZ / `ADCRB_FS_MAX_KHZ)
`endif

// ---- rtl/adcrb_pkg.sv ----
// Types shared by the converter register bank
package adcrb_pkg;
  typedef struct packed {
    logic start; logic [1:0] elem_conv_count_sel; logic [2:0] oversample_sel; logic continuous; logic rsv;
  } adcrb_ctrl_t;
  typedef struct packed {
    logic [1:0] converter_bias_sel; logic [1:0] amplifier_bias_sel;
    logic stage3_en; logic stage2_en; logic stage1_en; logic conv_en;
  } adcrb_bias_t;
  typedef struct packed {
    logic [1:0] sample_rate_sel; logic [1:0] stage2_gain_sel; logic [3:0] stage2_offset_sel;
  } adcrb_rate_t;
  typedef struct packed {logic stage1_gain_sel; logic [6:0] stage3_gain_sel;} adcrb_gain_t;
  typedef struct packed {logic rsv; logic [6:0] stage3_offset_sel;} adcrb_off3_t;
  typedef struct packed {logic busy; logic load_default; logic [4:0] input_chan_sel; logic ref_sel;} adcrb_insel_t;
  typedef struct packed {
    logic [1:0] rsv; logic [1:0] ref_chop_sel; logic pump_force_on; logic pump_force_off;
    logic ref_out_on_pin0; logic ext_ref_on_pin1;
  } adcrb_mode_t;
  // Analog settings handed to the amplifier chain and converter
  typedef struct packed {
    adcrb_bias_t bias; adcrb_rate_t rate; adcrb_gain_t gain; adcrb_off3_t off3;
    logic [4:0] input_chan_sel; logic ref_sel;
  } adcrb_analog_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} adcrb_fsm_t;
endpackage : adcrb_pkg

// ---- rtl/adcrb_bank.sv ----
// Converter control register bank with conversion sequencer
// Function
// - Writing 0x96 to external-address register takes two address LSBs from gp pins.
// - Result is two read-only bytes at 0x50/0x51, zero after reset.
// - Start bit 7 of conversion control begins a conversion; resets to zero.
// - Each conversion runs two-to-the-count-field elementary conversions.
// - Input is chopped between successive elementary conversions.
// - Oversampling of each elementary conversion is two to three plus field.
// - Continuous bit repeats conversions without a new start.
// - Bias selections reset 11; stage and converter enables reset 0.
// - Sample-rate field picks converter sampling frequency, reset 00.
// - Stage-two gain and offset selections applied, reset zero.
// - Stage-three offset and gain, stage-one gain applied; stage-three gain resets 0001100.
// - Default bit loads default configuration and starts a conversion.
// - Five-bit channel field routes the analog input, reset zero.
// - Reference selector: 0 battery supply, 1 reference pin.
// - Reference chop: 11 half rate, 10 elementary rate, 01 one, 00 zero.
// - Pump force-on beats force-off; force-off resets to one.
// - Mode bit 1 drives internal reference on gp pin 0.
// - Mode bit 0 accepts external reference on gp pin 1.
// - All registers reachable from the serial slave at listed addresses.
`timescale 1ns/1ns
`include "adcrb_defs.svh"
module adcrb_bank import adcrb_pkg::*; #(
  parameter logic [1:0] FUSE_ADDR_BITS = 2'b00
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  // Register access from the serial slave
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic [6:0] SLAVE_ADDR_OUT,
  // Pins and analog side
  input wire logic GP_PIN0_IN,
  input wire logic GP_PIN1_IN,
  input wire logic MOD_BIT_IN,
  input wire logic PUMP_AUTO_IN,
  output adcrb_analog_t CFG_OUT,
  output logic SAMPLE_OUT,
  output logic INPUT_CHOP_OUT,
  output logic REF_CHOP_OUT,
  output logic PUMP_ON_OUT,
  output logic REF_OUT_PIN0_OUT,
  output logic EXT_REF_PIN1_OUT
);
  typedef struct packed {
    logic [7:0] ext_cmd; logic ext_mode; logic [15:0] result;
    adcrb_ctrl_t ctrl; adcrb_bias_t bias; adcrb_rate_t rate; adcrb_gain_t gain;
    adcrb_off3_t off3; adcrb_insel_t insel; adcrb_mode_t mode; adcrb_fsm_t fsm;
    logic [15:0] div_cnt; logic tick; logic [10:0] samp_cnt; logic [3:0] elem_cnt;
    logic [15:0] acc; logic in_chop; logic ref_chop; logic pump_on; logic [7:0] rdata;
    logic [6:0] slave_addr; logic [3:0] sync_a; logic [3:0] sync_b;
  } adcrb_state_t;

  adcrb_state_t st;
  adcrb_state_t next_st;
  logic [10:0] osr_len;
  logic [3:0] nel_len;
  logic [15:0] div_lim;
  logic elem_end;
  logic conv_end;
  logic wr_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Derived lengths from the configuration
  assign osr_len = `ADCRB_OSR_BASE << st.ctrl.oversample_sel;
  assign nel_len = 4'h1 << st.ctrl.elem_conv_count_sel;
  assign div_lim = (16'(`ADCRB_FS_DIV) << st.rate.sample_rate_sel) - 16'h0001;
  assign elem_end = (st.fsm == ST_RUN) && st.tick && (st.samp_cnt == osr_len - 11'h001);
  assign conv_end = elem_end && (st.elem_cnt == nel_len - 4'h1);
  assign wr_hit = REG_WR_IN;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    // Pins pass two flops; only the second stage is read
    next_st.sync_a = {PUMP_AUTO_IN, MOD_BIT_IN, GP_PIN1_IN, GP_PIN0_IN};
    next_st.sync_b = st.sync_a;
    // Sample-rate divider, slowest rate at the largest selection
    next_st.tick = 1'b0;
    if (st.div_cnt >= div_lim) begin
      next_st.div_cnt = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.div_cnt = st.div_cnt + 16'h0001;
    end
    // Reference chop fixed levels follow the field at once
    if (st.mode.ref_chop_sel == 2'b01) next_st.ref_chop = 1'b1;
    if (st.mode.ref_chop_sel == 2'b00) next_st.ref_chop = 1'b0;
    // Conversion sequencer
    case (st.fsm)
      ST_IDLE: begin
        if (st.ctrl.start || st.ctrl.continuous) begin
          next_st.fsm = ST_RUN;
          next_st.insel.busy = 1'b1;
          next_st.acc = 16'h0000;
          next_st.samp_cnt = 11'h000;
          next_st.elem_cnt = 4'h0;
          next_st.in_chop = 1'b0;
        end
      end
      ST_RUN: begin
        if (st.tick) begin
          // Chopped input: inverted sense cancels modulator offset
          next_st.acc = st.acc + {15'h0000, st.sync_b[2] ^ st.in_chop};
          next_st.samp_cnt = st.samp_cnt + 11'h001;
        end
        if (elem_end) begin
          next_st.samp_cnt = 11'h000;
          next_st.elem_cnt = st.elem_cnt + 4'h1;
          next_st.in_chop = ~st.in_chop;
          if (st.mode.ref_chop_sel == 2'b10) next_st.ref_chop = ~st.ref_chop;
          if (st.mode.ref_chop_sel == 2'b11 && st.elem_cnt[0]) next_st.ref_chop = ~st.ref_chop;
        end
        if (conv_end) begin
          next_st.result = next_st.acc;
          next_st.insel.busy = 1'b0;
          next_st.ctrl.start = 1'b0;
          next_st.fsm = ST_IDLE; // Continuous restarts from idle
        end
      end
      default: next_st.fsm = ST_IDLE;
    endcase
    // Register writes; a write landing with the hardware clear of start wins
    if (wr_hit) begin
      case (REG_ADDR_IN)
        `ADCRB_OFF_EXT_CMD: begin
          next_st.ext_cmd = REG_WDATA_IN;
          if (REG_WDATA_IN == `ADCRB_EXT_ADDR_CMD) next_st.ext_mode = 1'b1;
        end
        `ADCRB_OFF_CTRL: begin
          next_st.ctrl = adcrb_ctrl_t'(REG_WDATA_IN & 8'hFE);
        end
        `ADCRB_OFF_BIAS: next_st.bias = adcrb_bias_t'(REG_WDATA_IN);
        `ADCRB_OFF_RATE: next_st.rate = adcrb_rate_t'(REG_WDATA_IN);
        `ADCRB_OFF_GAIN: next_st.gain = adcrb_gain_t'(REG_WDATA_IN);
        `ADCRB_OFF_OFF3: next_st.off3 = adcrb_off3_t'(REG_WDATA_IN);
        `ADCRB_OFF_INSEL: begin
          next_st.insel.input_chan_sel = REG_WDATA_IN[5:1];
          next_st.insel.ref_sel = REG_WDATA_IN[0];
          if (REG_WDATA_IN[6]) begin
            // Default load overrides the config and launches a conversion
            next_st.ctrl = adcrb_ctrl_t'(`ADCRB_RST_CTRL);
            next_st.ctrl.start = 1'b1;
            next_st.bias = adcrb_bias_t'(`ADCRB_RST_BIAS);
            next_st.rate = adcrb_rate_t'(`ADCRB_RST_RATE);
            next_st.gain = adcrb_gain_t'(`ADCRB_RST_GAIN);
            next_st.off3 = adcrb_off3_t'(`ADCRB_RST_OFF3);
          end
        end
        `ADCRB_OFF_MODE: begin
          next_st.mode = adcrb_mode_t'((REG_WDATA_IN & ~`ADCRB_MODE_RSV_MASK) | (`ADCRB_RST_MODE & `ADCRB_MODE_RSV_MASK));
        end
        default: next_st.ext_cmd = next_st.ext_cmd; // Result bytes and unmapped: ignored
      endcase
    end
    // Pump: force-on first, then force-off, else follow supply monitor
    next_st.pump_on = st.mode.pump_force_on | (~st.mode.pump_force_off & st.sync_b[3]);
    // Low address bits from pins once switched
    next_st.slave_addr = {`ADCRB_ADDR_HIGH, FUSE_ADDR_BITS, st.ext_mode ? st.sync_b[1:0] : 2'b00};
    // Read data, one cycle after the strobe; unmapped reads zero
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `ADCRB_OFF_EXT_CMD: next_st.rdata = st.ext_cmd;
        `ADCRB_OFF_RES_LO: next_st.rdata = st.result[7:0];
        `ADCRB_OFF_RES_HI: next_st.rdata = st.result[15:8];
        `ADCRB_OFF_CTRL: next_st.rdata = st.ctrl;
        `ADCRB_OFF_BIAS: next_st.rdata = st.bias;
        `ADCRB_OFF_RATE: next_st.rdata = st.rate;
        `ADCRB_OFF_GAIN: next_st.rdata = st.gain;
        `ADCRB_OFF_OFF3: next_st.rdata = st.off3;
        `ADCRB_OFF_INSEL: next_st.rdata = st.insel;
        `ADCRB_OFF_MODE: next_st.rdata = st.mode;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      st <= '0;
      st.ext_cmd <= `ADCRB_RST_EXT_CMD;
      st.ctrl <= adcrb_ctrl_t'(`ADCRB_RST_CTRL);
      st.bias <= adcrb_bias_t'(`ADCRB_RST_BIAS);
      st.rate <= adcrb_rate_t'(`ADCRB_RST_RATE);
      st.gain <= adcrb_gain_t'(`ADCRB_RST_GAIN);
      st.off3 <= adcrb_off3_t'(`ADCRB_RST_OFF3);
      st.insel <= adcrb_insel_t'(`ADCRB_RST_INSEL);
      st.mode <= adcrb_mode_t'(`ADCRB_RST_MODE);
      st.fsm <= ST_IDLE;
      st.slave_addr <= {`ADCRB_ADDR_HIGH, 4'h0};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from the state register
  assign REG_RDATA_OUT = st.rdata;
  assign SLAVE_ADDR_OUT = st.slave_addr;
  assign CFG_OUT = {st.bias, st.rate, st.gain, st.off3, st.insel.input_chan_sel, st.insel.ref_sel};
  assign SAMPLE_OUT = st.tick;
  assign INPUT_CHOP_OUT = st.in_chop;
  assign REF_CHOP_OUT = st.ref_chop;
  assign PUMP_ON_OUT = st.pump_on;
  assign REF_OUT_PIN0_OUT = st.mode.ref_out_on_pin0;
  assign EXT_REF_PIN1_OUT = st.mode.ext_ref_on_pin1;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence s_conv_done; st.fsm == ST_RUN && conv_end; endsequence
  sequence s_idle_cont; st.fsm == ST_IDLE && st.ctrl.continuous; endsequence

  chk_ext_mode_set: assert property (
    wr_hit && REG_ADDR_IN == `ADCRB_OFF_EXT_CMD && REG_WDATA_IN == `ADCRB_EXT_ADDR_CMD
    |=> st.ext_mode ##1 SLAVE_ADDR_OUT[1:0] == $past(st.sync_b[1:0], 1))
    else $error("address pins not taken after command");
  chk_result_readonly: assert property (
    wr_hit && REG_ADDR_IN == `ADCRB_OFF_RES_LO && st.fsm == ST_IDLE |=> $stable(st.result))
    else $error("result changed by a write");
  chk_start_runs: assert property (
    st.fsm == ST_IDLE && st.ctrl.start |=> st.fsm == ST_RUN && st.insel.busy)
    else $error("start did not begin a conversion");
  chk_samp_bound: assert property (
    st.fsm == ST_RUN |-> st.samp_cnt < osr_len)
    else $error("oversample count beyond ratio");
  chk_chop_toggle: assert property (
    elem_end |=> st.in_chop != $past(st.in_chop))
    else $error("input chop did not toggle");
  chk_busy_clears: assert property (
    s_conv_done |=> !st.insel.busy && st.result == $past(next_st.acc))
    else $error("busy or result wrong at end");
  chk_cont_restart: assert property (
    s_conv_done ##1 s_idle_cont |=> st.fsm == ST_RUN)
    else $error("continuous mode did not restart");
  chk_pump_priority: assert property (
    st.mode.pump_force_on |=> PUMP_ON_OUT)
    else $error("pump force on lost");
  chk_ref_chop_one: assert property (
    st.mode.ref_chop_sel == 2'b01 |=> REF_CHOP_OUT)
    else $error("reference chop not held high");
  chk_ref_pin0: assert property (
    wr_hit && REG_ADDR_IN == `ADCRB_OFF_MODE
    |=> REF_OUT_PIN0_OUT == $past(REG_WDATA_IN[1]) && EXT_REF_PIN1_OUT == $past(REG_WDATA_IN[0]))
    else $error("reference pin enables mismatch");
endmodule : adcrb_bank

// ---- tb/adcrb_host.sv ----
// Host model: byte-level register strobes as the serial slave hands them on
`timescale 1ns/1ns
module adcrb_host (
  // Clock and returned data
  input wire logic CLK_IN,
  input wire logic [7:0] REG_RDATA_IN,
  // Strobes with address and data
  output logic REG_WR_OUT,
  output logic REG_RD_OUT,
  output logic [7:0] REG_ADDR_OUT,
  output logic [7:0] REG_WDATA_OUT
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle at time zero; unqualified lines park on a moving pattern
  initial begin
    REG_WR_OUT = 1'b0;
    REG_RD_OUT = 1'b0;
    REG_ADDR_OUT = 8'hA5;
    REG_WDATA_OUT = 8'h5A;
  end

  // One strobe cycle; lines held until the taking edge, then strobes cleared and address and data inverted
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge CLK_IN);
    #2;
    REG_WR_OUT = wr;
    REG_RD_OUT = ~wr;
    REG_ADDR_OUT = a;
    REG_WDATA_OUT = d;
    @(posedge CLK_IN);
    #2;
    q = REG_RDATA_IN;
    REG_WR_OUT = 1'b0;
    REG_RD_OUT = 1'b0;
    REG_ADDR_OUT = ~a;
    REG_WDATA_OUT = ~d;
  endtask : xfer

  // Callers pass reserved bits at their reset levels
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  // Read data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask : rd
endmodule : adcrb_host

// ---- tb/testbench.sv ----
// Self-checking bench for the converter register bank
`timescale 1ns/1ns
module testbench;
  import adcrb_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr, rd, gp0 = 1'b1, gp1 = 1'b1, mod_bit = 1'b1, pump_auto = 1'b1;
  logic [7:0] addr, wdata, rdata;
  logic [6:0] slave_addr;
  adcrb_analog_t cfg;
  logic sample, in_chop, ref_chop, pump_on, pin0_out, pin1_out;
  logic [15:0] cnt = 16'h0000, gap = 16'h0000;
  int err_total = 0, n_tests = 0;
  // Address, reset value, write data, readback
  logic [31:0] rows [11] = '{32'h4300_5555, 32'h5000_FF00, 32'h5100_FF00, 32'h5228_3C3C, 32'h53F0_A5A5,
    32'h5400_5A5A, 32'h550C_8C8C, 32'h5600_7F7F, 32'h5700_3F3F, 32'h7084_A4A4, 32'h6000_FF00};
  // Mode byte, then {pump, pin0, pin1, ref chop}
  logic [15:0] modes [3] = '{16'h9C09, 16'h8604, 16'h810A};
  ////////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end

  adcrb_host adcrb_host_inst (.CLK_IN(clk), .REG_RDATA_IN(rdata), .REG_WR_OUT(wr), .REG_RD_OUT(rd),
    .REG_ADDR_OUT(addr), .REG_WDATA_OUT(wdata));
  adcrb_bank #(.FUSE_ADDR_BITS(2'b00)) adcrb_bank_inst (.CLK_IN(clk), .NRST_IN(nrst), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
    .SLAVE_ADDR_OUT(slave_addr), .GP_PIN0_IN(gp0), .GP_PIN1_IN(gp1), .MOD_BIT_IN(mod_bit),
    .PUMP_AUTO_IN(pump_auto), .CFG_OUT(cfg), .SAMPLE_OUT(sample), .INPUT_CHOP_OUT(in_chop),
    .REF_CHOP_OUT(ref_chop), .PUMP_ON_OUT(pump_on), .REF_OUT_PIN0_OUT(pin0_out), .EXT_REF_PIN1_OUT(pin1_out));

  // Spacing of sampling ticks, in clocks
  always @(posedge clk) begin
    cnt <= sample ? 16'h0001 : cnt + 16'h0001;
    if (sample) gap <= cnt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // Read one register and compare it
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    adcrb_host_inst.rd(a, v);
    check({8'h00, v}, {8'h00, e});
  endtask : rdchk

  // Poll the activity flag until it drops, bounded
  task automatic wait_idle();
    logic [7:0] v;
    v = 8'hFF;
    for (int i = 0; i < 600 && v[7] !== 1'b0; i++) begin
      repeat (20) @(posedge clk);
      adcrb_host_inst.rd(8'h57, v);
    end
    check({15'h0000, v[7]}, 16'h0000);
  endtask : wait_idle

  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Watchdog: the whole run needs under 25000 clocks
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    finish_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    #2 nrst = 1'b1;
    check({9'h000, slave_addr}, 16'h0040);
    foreach (rows[i]) rdchk(rows[i][31:24], rows[i][23:16]);
    foreach (rows[i]) adcrb_host_inst.wr(rows[i][31:24], rows[i][15:8]);
    foreach (rows[i]) rdchk(rows[i][31:24], rows[i][7:0]);
    check({cfg.bias, cfg.rate}, 16'hA55A);
    check({cfg.gain, cfg.off3}, 16'h8C7F);
    check({10'h000, cfg.input_chan_sel, cfg.ref_sel}, 16'h003F);
    foreach (modes[i]) begin
      adcrb_host_inst.wr(8'h70, modes[i][15:8]);
      repeat (5) @(posedge clk);
      check({12'h000, pump_on, pin0_out, pin1_out, ref_chop}, {12'h000, modes[i][3:0]});
    end
    // Address pins matter only after the exact command
    repeat (5) @(posedge clk);
    check({9'h000, slave_addr}, 16'h0040);
    adcrb_host_inst.wr(8'h43, 8'h96);
    repeat (4) @(posedge clk);
    check({9'h000, slave_addr}, 16'h0043);
    // Two elements of 8 at the slower rate; chopping halves a constant input
    adcrb_host_inst.wr(8'h52, 8'hA0);
    rdchk(8'h57, 8'hBF);
    wait_idle();
    check(gap, 16'd200);
    rdchk(8'h50, 8'h08);
    rdchk(8'h51, 8'h00);
    rdchk(8'h52, 8'h20);
    // Default bit restores configuration and starts; channel and reference taken from the written byte
    adcrb_host_inst.wr(8'h70, 8'hB4);
    adcrb_host_inst.wr(8'h57, 8'h46);
    rdchk(8'h53, 8'hF0);
    rdchk(8'h57, 8'h86);
    rdchk(8'h52, 8'hA8);
    wait_idle();
    check(gap, 16'd100);
    rdchk(8'h50, 8'h20);
    check({15'h0000, ref_chop}, 16'h0001);
    // Continuous mode keeps converting well past one 800-clock conversion
    adcrb_host_inst.wr(8'h52, 8'h82);
    repeat (2000) @(posedge clk);
    rdchk(8'h57, 8'h86);
    // Reset in mid-conversion
    @(posedge clk);
    #2 nrst = 1'b0;
    repeat (2) @(posedge clk);
    #2 nrst = 1'b1;
    rdchk(8'h52, 8'h28);
    rdchk(8'h57, 8'h00);
    rdchk(8'h50, 8'h00);
    rdchk(8'h70, 8'h84);
    check({9'h000, slave_addr}, 16'h0040);
    finish_test();
  end
endmodule : testbench
